// [logic/actb_trim_bank.sv]
`timescale 1ns/1ns
module actb_trim_bank import actb_pkg::*; #(
  parameter logic [6:0]        DEV_ADDR     = 7'h08,  // arbitrary bus address
  parameter logic [GAIN_W-1:0] GAIN_TRIM    = 5'h00,  // production value, plain default
  parameter logic [OFFS_W-1:0] OFFSET_TRIM  = 8'h00,  // production value, plain default
  parameter int                NUM_GROUPS   = 3,
  parameter int                MEAS_CNT     = MEAS_CYCLES,
  parameter int                SETTLE_CNT   = ALERT_CYCLES
) (
  input  wire logic                  CLK,
  input  wire logic                  RSTN,
  input  wire logic                  SCL_IN,
  input  wire logic                  SDA_IN,
  output logic                       SDA_OUT,
  output logic                       SDA_OE_N,
  output logic [GAIN_W-1:0]          GAIN_TRIM_CODE,
  output logic signed [OFFS_W-1:0]   OFFSET_TRIM_CODE,
  input  wire logic [NUM_GROUPS-1:0] MEAS_EN,
  output logic [NUM_GROUPS-1:0]      MEAS_TICK,
  input  wire logic                  ALERT_SET_IN,
  input  wire logic                  ALERT_CLR_IN,
  input  wire logic                  ALERT_IN,
  output logic                       ALERT_OUT,
  output logic                       ALERT_OE_N,
  output logic                       ALERT_LEVEL
);
  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  actb_state_e st_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  rx_shift_reg;
  logic [7:0]  tx_shift_reg;
  logic [7:0]  ptr_reg;
  logic        rw_reg;
  logic        nack_reg;
  logic        load_rd_reg;
  logic [7:0]  load_ptr_reg;
  logic [1:0]  alert_sync_reg;
  logic        settle_run_reg;
  logic [31:0] settle_cnt_reg;

  // edges look only at the second and third stages, never the first
  wire scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
  wire scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
  wire bus_start = scl_sync_reg[1] & sda_sync_reg[2] & ~sda_sync_reg[1];
  wire bus_stop  = scl_sync_reg[1] & ~sda_sync_reg[2] & sda_sync_reg[1];
  wire sda_bit   = sda_sync_reg[1];
  wire byte_done = (bit_cnt_reg == BYTE_BITS);
  wire addr_hit  = (rx_shift_reg[7:1] == DEV_ADDR);

  // read decode; unmapped pointers return zero
  wire [7:0] gain_hi_byte =
    8'(GAIN_TRIM_CODE[GAIN_W-1 -: GAIN_HI_MSB-GAIN_HI_LSB+1]) << GAIN_HI_LSB;
  wire [7:0] gain_lo_byte = 8'(GAIN_TRIM_CODE[GAIN_LO_MSB-GAIN_LO_LSB:0]) << GAIN_LO_LSB;
  wire [7:0] rd_data = (ptr_reg == GAIN_HI_OFFSET) ? gain_hi_byte :
                       (ptr_reg == OFFSET_OFFSET)  ? OFFSET_TRIM_CODE :
                       (ptr_reg == GAIN_LO_OFFSET) ? gain_lo_byte : 8'h00;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], SCL_IN};
      sda_sync_reg <= {sda_sync_reg[1:0], SDA_IN};
    end
  end

  // trim values are loaded once and have no write path at all
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      GAIN_TRIM_CODE   <= GAIN_TRIM;
      OFFSET_TRIM_CODE <= OFFSET_TRIM;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_reg       <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      ptr_reg      <= 8'h00;
      rw_reg       <= 1'b0;
      nack_reg     <= 1'b0;
      load_rd_reg  <= 1'b0;
      load_ptr_reg <= 8'h00;
      SDA_OUT      <= 1'b0;
      SDA_OE_N     <= 1'b1;
    end else begin
      load_rd_reg <= 1'b0;
      if (bus_start) begin
        st_reg      <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        SDA_OE_N    <= 1'b1;
      end else if (bus_stop) begin
        st_reg   <= ST_IDLE;
        SDA_OE_N <= 1'b1;
      end else if (scl_rise) begin
        if (st_reg == ST_ADDR || st_reg == ST_PTR || st_reg == ST_WR) begin
          rx_shift_reg <= {rx_shift_reg[6:0], sda_bit};
          bit_cnt_reg  <= bit_cnt_reg + 4'h1;
        end else if (st_reg == ST_RACK) begin
          nack_reg <= sda_bit;
        end
      end else if (scl_fall) begin
        case (st_reg)
          ST_ADDR: begin
            if (byte_done && addr_hit) begin
              st_reg   <= ST_ACKA;
              rw_reg   <= rx_shift_reg[0];
              SDA_OE_N <= 1'b0;
            end else if (byte_done) begin
              st_reg <= ST_IDLE;
            end
          end
          ST_ACKA: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              st_reg       <= ST_RD;
              tx_shift_reg <= {rd_data[6:0], 1'b0};
              load_rd_reg  <= 1'b1;
              load_ptr_reg <= ptr_reg;
              SDA_OE_N     <= rd_data[7];
            end else begin
              st_reg   <= ST_PTR;
              SDA_OE_N <= 1'b1;
            end
          end
          ST_PTR: begin
            if (byte_done) begin
              st_reg   <= ST_ACKP;
              ptr_reg  <= rx_shift_reg;
              SDA_OE_N <= 1'b0;
            end
          end
          ST_ACKP, ST_ACKW: begin
            st_reg      <= ST_WR;
            bit_cnt_reg <= 4'h0;
            SDA_OE_N    <= 1'b1;
          end
          ST_WR: begin
            // data byte is acknowledged and discarded; pointer still advances
            if (byte_done) begin
              st_reg   <= ST_ACKW;
              ptr_reg  <= ptr_reg + 8'h01;
              SDA_OE_N <= 1'b0;
            end
          end
          ST_RD: begin
            if (bit_cnt_reg == BYTE_BITS - 4'h1) begin
              st_reg   <= ST_RACK;
              ptr_reg  <= ptr_reg + 8'h01;
              SDA_OE_N <= 1'b1;
            end else begin
              bit_cnt_reg  <= bit_cnt_reg + 4'h1;
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              SDA_OE_N     <= tx_shift_reg[7];
            end
          end
          ST_RACK: begin
            bit_cnt_reg <= 4'h0;
            if (nack_reg) begin
              st_reg <= ST_IDLE;
            end else begin
              st_reg       <= ST_RD;
              tx_shift_reg <= {rd_data[6:0], 1'b0};
              load_rd_reg  <= 1'b1;
              load_ptr_reg <= ptr_reg;
              SDA_OE_N     <= rd_data[7];
            end
          end
          default: st_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // one free-running timeline per group; no shared phase, so each group keeps the fixed offset set by its enable time
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
      logic [31:0] cnt_reg;
      wire         wrap = (cnt_reg == 32'(MEAS_CNT - 1));
      always_ff @(posedge CLK) begin
        if (!RSTN || !MEAS_EN[g]) begin
          cnt_reg      <= 32'h0;
          MEAS_TICK[g] <= 1'b0;
        end else begin
          cnt_reg      <= wrap ? 32'h0 : cnt_reg + 32'h1;
          MEAS_TICK[g] <= wrap;
        end
      end
      a_group_tick_gap: assert property (@(posedge CLK) disable iff (!RSTN)
        MEAS_TICK[g] |=> !MEAS_TICK[g] [*8]) else $error("group tick too close");
      a_group_idle_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
        !MEAS_EN[g] |=> !MEAS_TICK[g]) else $error("tick while group disabled");
    end
  endgenerate

  // alert: drive high, release on clear, sample after the pin has had time to fall
  wire settle_done = settle_run_reg && (settle_cnt_reg == 32'(SETTLE_CNT - 1));
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      alert_sync_reg <= 2'h0;
      ALERT_OUT      <= 1'b0;
      ALERT_OE_N     <= 1'b1;
      ALERT_LEVEL    <= 1'b0;
      settle_run_reg <= 1'b0;
      settle_cnt_reg <= 32'h0;
    end else begin
      alert_sync_reg <= {alert_sync_reg[0], ALERT_IN};
      if (ALERT_SET_IN) begin
        // a set in the same cycle as a clear wins
        ALERT_OUT      <= 1'b1;
        ALERT_OE_N     <= 1'b0;
        settle_run_reg <= 1'b0;
      end else if (ALERT_CLR_IN) begin
        ALERT_OUT      <= 1'b0;
        ALERT_OE_N     <= 1'b1;
        settle_run_reg <= 1'b1;
        settle_cnt_reg <= 32'h0;
      end else if (settle_done) begin
        settle_run_reg <= 1'b0;
        ALERT_LEVEL    <= alert_sync_reg[1];
      end else if (settle_run_reg) begin
        settle_cnt_reg <= settle_cnt_reg + 32'h1;
      end else if (ALERT_OE_N) begin
        ALERT_LEVEL <= alert_sync_reg[1];
      end
    end
  end

  sequence s_alert_clear;
    !ALERT_SET_IN && ALERT_CLR_IN;
  endsequence
  sequence s_alert_released;
    ALERT_OE_N && !ALERT_OUT;
  endsequence

  a_alert_drive_high: assert property (@(posedge CLK) disable iff (!RSTN)
    ALERT_SET_IN |=> !ALERT_OE_N && ALERT_OUT) else $error("alert not driven");
  a_alert_release_clear: assert property (@(posedge CLK) disable iff (!RSTN)
    s_alert_clear |=> s_alert_released) else $error("alert not released");
  a_alert_sample_late: assert property (@(posedge CLK) disable iff (!RSTN)
    s_alert_clear ##1 (!ALERT_SET_IN && !ALERT_CLR_IN) [*2] |-> $stable(ALERT_LEVEL))
    else $error("alert sampled before settling");
  a_gain_high_field: assert property (@(posedge CLK) disable iff (!RSTN)
    load_rd_reg && load_ptr_reg == GAIN_HI_OFFSET |->
      {SDA_OE_N, tx_shift_reg[7:1]} == {4'h0, GAIN_TRIM_CODE[4:3], 2'h0})
    else $error("gain high byte wrong");
  a_gain_low_field: assert property (@(posedge CLK) disable iff (!RSTN)
    load_rd_reg && load_ptr_reg == GAIN_LO_OFFSET |->
      {SDA_OE_N, tx_shift_reg[7:1]} == {GAIN_TRIM_CODE[2:0], 5'h00})
    else $error("gain low byte wrong");
  a_offset_full_byte: assert property (@(posedge CLK) disable iff (!RSTN)
    load_rd_reg && load_ptr_reg == OFFSET_OFFSET |->
      {SDA_OE_N, tx_shift_reg[7:1]} == OFFSET_TRIM_CODE)
    else $error("offset byte wrong");
  a_trim_held_fixed: assert property (@(posedge CLK) disable iff (!RSTN)
    ##1 $stable(GAIN_TRIM_CODE) && $stable(OFFSET_TRIM_CODE))
    else $error("trim value changed");
  a_offset_sign_ext: assert property (@(posedge CLK) disable iff (!RSTN)
    load_rd_reg && load_ptr_reg == OFFSET_OFFSET |->
      SDA_OE_N == (OFFSET_TRIM_CODE < 0))
    else $error("offset sign wrong");
endmodule

// [logic/actb_pkg.sv]
// Contract
// - gain trim bits 4:3 read at 0x50 bits 3:2, other bits zero
// - gain trim bits 2:0 read at 0x59 bits 7:5, lower bits zero
// - offset trim is signed two's complement in 1 mV steps
// - offset trim occupies all eight bits at 0x51
// - each five-cell group runs its own free 250 ms timeline
// - alert pin driven, released on clear, then sampled as input
package actb_pkg;
  localparam logic [7:0] GAIN_HI_OFFSET = 8'h50;
  localparam logic [7:0] OFFSET_OFFSET  = 8'h51;
  localparam logic [7:0] GAIN_LO_OFFSET = 8'h59;
  localparam int GAIN_HI_MSB = 3;
  localparam int GAIN_HI_LSB = 2;
  localparam int GAIN_LO_MSB = 7;
  localparam int GAIN_LO_LSB = 5;
  localparam int GAIN_W      = 5;
  localparam int OFFS_W      = 8;
  localparam int CLK_HZ          = 50_000_000;
  localparam int MEAS_PERIOD_MS  = 250;
  localparam int MEAS_CYCLES     = MEAS_PERIOD_MS * (CLK_HZ / 1000);
  localparam int ALERT_SETTLE_US = 250;
  localparam int ALERT_CYCLES    = ALERT_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ACKA = 4'b0010,
    ST_PTR  = 4'b0011,
    ST_ACKP = 4'b0100,
    ST_WR   = 4'b0101,
    ST_ACKW = 4'b0110,
    ST_RD   = 4'b0111,
    ST_RACK = 4'b1000
  } actb_state_e;
endpackage

// [testbench/actb_host_model.sv]
`timescale 1ns/1ns
module actb_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull_n,
  output logic      rd_stb,
  output logic [7:0] rd_data
);
  initial begin
    scl = 1;
    pull_n = 1;
    rd_stb = 0;
    rd_data = 0;
  end
  // host view of the trims and threshold code
  function automatic int gain_uv(input logic [4:0] c);
    return 365 + int'(c);
  endfunction
  function automatic int offset_mv(input logic [7:0] c);
    return int'(signed'(c));
  endfunction
  function automatic logic [13:0] ov_code(input logic [7:0] m);
    return {2'b10, m, 4'b1000};
  endfunction
  // quarter bit of 5 clocks keeps each scl phase at 10, above the 8 minimum
  task automatic qtr();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    qtr(); pull_n = b;
    qtr(); scl = 1;
    qtr(); r = sda;
    qtr(); scl = 0;
  endtask
  task automatic start();
    qtr(); pull_n = 1;
    qtr(); scl = 1;
    qtr(); pull_n = 0;
    qtr(); scl = 0;
  endtask
  task automatic stop();
    qtr(); pull_n = 0;
    qtr(); scl = 1;
    qtr(); pull_n = 1;
    qtr();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, nack);
  endtask
  task automatic rbyte(input logic last);
    logic [7:0] v;
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, r);
    rd_data = v;
    rd_stb = 1;
    @(posedge clk);
    #1;
    rd_stb = 0;
  endtask
endmodule

// [testbench/adc_calibration_trim_bank_test.sv]
`timescale 1ns/1ns
module adc_calibration_trim_bank_test import actb_pkg::*;;
  localparam logic [4:0] GT = 5'h1b;
  localparam logic [7:0] OT = 8'h80;
  localparam logic [6:0] DA = 7'h08;
  logic clk, rstn, scl, sda_oe_n, sda_out, a_set, a_clr, a_out, a_oe_n, a_lvl, a_ext;
  logic pull_n, rd_stb, nack;
  logic [4:0] gain;
  logic [7:0] offs, rd_data, exp_q[$];
  logic [2:0] m_en, m_tick;
  logic [31:0] lfsr;
  int err_count, num_checks, cyc, tcnt[3], ticks[3];
  wire logic sda = pull_n & (sda_oe_n | sda_out);
  wire logic a_pin = a_oe_n ? a_ext : a_out;
  actb_trim_bank #(.DEV_ADDR(DA), .GAIN_TRIM(GT), .OFFSET_TRIM(OT), .NUM_GROUPS(3),
    .MEAS_CNT(20), .SETTLE_CNT(5)) i_dut (.CLK(clk), .RSTN(rstn), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .GAIN_TRIM_CODE(gain),
    .OFFSET_TRIM_CODE(offs), .MEAS_EN(m_en), .MEAS_TICK(m_tick), .ALERT_SET_IN(a_set),
    .ALERT_CLR_IN(a_clr), .ALERT_IN(a_pin), .ALERT_OUT(a_out), .ALERT_OE_N(a_oe_n),
    .ALERT_LEVEL(a_lvl));
  actb_host_model i_host (.clk(clk), .sda(sda), .scl(scl), .pull_n(pull_n),
    .rd_stb(rd_stb), .rd_data(rd_data));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  always @(posedge clk) begin
    if (rd_stb === 1'b1) check(rd_data, exp_q.pop_front());
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk) begin
    for (int g = 0; g < 3; g++) begin
      if (m_tick[g] === 1'b1) begin
        if (ticks[g] > 0) check(8'(tcnt[g] + 1), 8'd20);
        ticks[g]++;
        tcnt[g] = 0;
      end else tcnt[g]++;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_ptr(input logic [7:0] p);
    i_host.start();
    i_host.wbyte({DA, 1'b0}, nack);
    check(8'(nack), 8'h00);
    i_host.wbyte(p, nack);
    check(8'(nack), 8'h00);
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    set_ptr(p);
    i_host.stop();
    i_host.start();
    i_host.wbyte({DA, 1'b1}, nack);
    check(8'(nack), 8'h00);
    for (int i = 0; i < n; i++) i_host.rbyte(i == n - 1);
    i_host.stop();
  endtask
  // random bytes from the lfsr; writes are acked yet must not stick
  task automatic wr_rand(input logic [7:0] p, input int n);
    set_ptr(p);
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      i_host.wbyte(lfsr[7:0], nack);
      check(8'(nack), 8'h00);
    end
    i_host.stop();
  endtask
  initial begin
    {rstn, a_set, a_clr, a_ext, m_en} = '0;
    lfsr = 32'hf6ea;
    tick(2);
    rstn = 1;
    tick(3);
    check(8'({sda_oe_n, a_oe_n}), 8'h03);
    check(8'(gain), 8'(GT));
    check(offs, OT);
    check(8'(i_host.gain_uv(gain) - 300), 8'd92);
    check(8'(i_host.offset_mv(offs) + 200), 8'd72);
    check(8'(i_host.ov_code(8'hac)), 8'hc8);
    check(8'(i_host.ov_code(8'hac) >> 8), 8'h2a);
    m_en = 3'b001;
    tick(7);
    m_en = 3'b011;
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        wr_rand(GAIN_HI_OFFSET, 2);
        wr_rand(GAIN_LO_OFFSET, 1);
      end
      exp_q.push_back({4'h0, GT[4:3], 2'b00});
      exp_q.push_back(OT);
      exp_q.push_back(8'h00);
      rd(GAIN_HI_OFFSET, 3);
      exp_q.push_back({GT[2:0], 5'h00});
      rd(GAIN_LO_OFFSET, 1);
    end
    check({gain, offs[2:0]}, {GT, OT[2:0]});
    i_host.start();
    i_host.wbyte({DA ^ 7'h01, 1'b0}, nack);
    check(8'(nack), 8'h01);
    i_host.stop();
    a_ext = 1;
    tick(5);
    a_set = 1;
    tick(1);
    a_set = 0;
    check(8'({a_oe_n, a_out}), 8'h01);
    a_ext = 0;
    a_clr = 1;
    tick(1);
    a_clr = 0;
    check(8'({a_oe_n, a_out}), 8'h02);
    tick(3);
    check(8'(a_lvl), 8'h01);
    tick(10);
    check(8'(a_lvl), 8'h00);
    {a_set, a_clr} = 2'b11;
    tick(1);
    {a_set, a_clr} = 2'b00;
    check(8'({a_oe_n, a_out}), 8'h01);
    tick(40);
    check(8'({ticks[2] == 0, ticks[1] > 0, exp_q.size() == 0}), 8'h07);
    print_verdict();
  end
endmodule
